// ===== cbsu_consts.svh
// constant definitions for the conditional branch and skip unit
`ifndef CBSU_CONSTS_SVH
`define CBSU_CONSTS_SVH

// ==========================================================
// status flag bit positions
`define CBSU_FLAG_C          3'd0
`define CBSU_FLAG_Z          3'd1
`define CBSU_FLAG_N          3'd2
`define CBSU_FLAG_V          3'd3
`define CBSU_FLAG_S          3'd4
`define CBSU_FLAG_H          3'd5
`define CBSU_FLAG_T          3'd6

// ==========================================================
// program counter steps
`define CBSU_PC_STEP         16'h0001
`define CBSU_SKIP_ONE_WORD   16'h0002
`define CBSU_SKIP_TWO_WORD   16'h0003

// ==========================================================
// cycle costs
`define CBSU_COST_ONE        2'h1
`define CBSU_COST_TWO        2'h2
`define CBSU_COST_THREE      2'h3

// ==========================================================
// register byte addresses and fields
`define CBSU_ADDR_CTRL       8'h00
`define CBSU_ADDR_STATUS     8'h04
`define CBSU_ADDR_COUNT      8'h08
`define CBSU_CTRL_EN_BIT     0
`define CBSU_CTRL_RESET      1'b1
`define CBSU_STATUS_BUSY_BIT 0
`define CBSU_STATUS_TAKEN_BIT 1

`endif

// ===== cbsu_pkg.sv
// types shared by the conditional branch and skip unit
package cbsu_pkg;

    // ==========================================================
    // instruction codes
    typedef enum logic [4:0] {
        OP_SKIP_IO_CLEAR        = 5'h00,
        OP_IO_BIT_SET_SKIP      = 5'h01,
        OP_BRANCH_FLAG_SET      = 5'h02,
        OP_BRANCH_FLAG_CLEAR    = 5'h03,
        OP_BRANCH_ON_EQUAL      = 5'h04,
        OP_BRANCH_ON_UNEQUAL    = 5'h05,
        OP_BRANCH_CARRY_SET     = 5'h06,
        OP_BRANCH_CARRY_CLEAR   = 5'h07,
        OP_BRANCH_UNSIGNED_GE   = 5'h08,
        OP_BRANCH_UNSIGNED_LT   = 5'h09,
        OP_BRANCH_NEGATIVE      = 5'h0a,
        OP_BRANCH_NONNEGATIVE   = 5'h0b,
        OP_BRANCH_SIGNED_GE     = 5'h0c,
        OP_BRANCH_SIGNED_LT     = 5'h0d,
        OP_BRANCH_HALFCARRY_SET = 5'h0e,
        OP_BRANCH_HALFCARRY_CLR = 5'h0f,
        OP_BRANCH_TRANSFER_SET  = 5'h10
    } cbsu_op_t;

    // ==========================================================
    // control states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } cbsu_state_t;

    // ==========================================================
    // instruction as issued by decode
    typedef struct packed {
        cbsu_op_t    op;
        logic [2:0]  bit_index;
        logic [6:0]  offset;
        logic        next_two_word;
        logic [15:0] pc;
    } cbsu_insn_t;

    // ==========================================================
    // complete register state of the unit
    typedef struct packed {
        cbsu_state_t fsm;
        logic [1:0]  cnt;
        cbsu_insn_t  insn;
        logic [7:0]  flags;
        logic [7:0]  io;
        logic        taken;
        logic        done;
        logic [15:0] pc_value;
        logic        enable;
        logic [15:0] taken_count;
        logic        ack;
        logic [31:0] rdat;
    } cbsu_regs_t;

endpackage

// ===== cbsu_cond.sv
// condition evaluation for branch and skip instructions
`timescale 1ns/1ps
`include "cbsu_consts.svh"

module cbsu_cond (
    // instruction operands
    input  wire cbsu_pkg::cbsu_op_t op,
    input  wire logic [2:0]         bit_index,
    // tested state
    input  wire logic [7:0]         flags,
    input  wire logic [7:0]         io_byte,
    // result
    output logic                    taken,
    output logic                    is_skip
);
    import cbsu_pkg::*;

    // ==========================================================
    // condition select
    always_comb
    begin
        is_skip = 1'b0;
        case (op)
            OP_SKIP_IO_CLEAR:
            begin
                taken   = ~io_byte[bit_index];
                is_skip = 1'b1;
            end
            OP_IO_BIT_SET_SKIP:
            begin
                taken   = io_byte[bit_index];
                is_skip = 1'b1;
            end
            OP_BRANCH_FLAG_SET:      taken = flags[bit_index];
            OP_BRANCH_FLAG_CLEAR:    taken = ~flags[bit_index];
            OP_BRANCH_ON_EQUAL:      taken = flags[`CBSU_FLAG_Z];
            OP_BRANCH_ON_UNEQUAL:    taken = ~flags[`CBSU_FLAG_Z];
            OP_BRANCH_CARRY_SET:     taken = flags[`CBSU_FLAG_C];
            OP_BRANCH_CARRY_CLEAR:   taken = ~flags[`CBSU_FLAG_C];
            OP_BRANCH_UNSIGNED_GE:   taken = ~flags[`CBSU_FLAG_C];
            OP_BRANCH_UNSIGNED_LT:   taken = flags[`CBSU_FLAG_C];
            OP_BRANCH_NEGATIVE:      taken = flags[`CBSU_FLAG_N];
            OP_BRANCH_NONNEGATIVE:   taken = ~flags[`CBSU_FLAG_N];
            OP_BRANCH_SIGNED_GE:     taken = ~(flags[`CBSU_FLAG_N] ^ flags[`CBSU_FLAG_V]);
            OP_BRANCH_SIGNED_LT:     taken = flags[`CBSU_FLAG_N] ^ flags[`CBSU_FLAG_V];
            OP_BRANCH_HALFCARRY_SET: taken = flags[`CBSU_FLAG_H];
            OP_BRANCH_HALFCARRY_CLR: taken = ~flags[`CBSU_FLAG_H];
            OP_BRANCH_TRANSFER_SET:  taken = flags[`CBSU_FLAG_T];
            default:                 taken = 1'b0;
        endcase
    end

endmodule

// ===== cbsu_top.sv
// conditional branch and skip unit with its register slave
// ==========================================================
`timescale 1ns/1ps
`include "cbsu_consts.svh"

module cbsu_top (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // instruction issue
    input  wire logic                 insn_valid,
    input  wire cbsu_pkg::cbsu_insn_t insn,
    output logic                      insn_ready,
    // tested state
    input  wire logic [7:0]           status_flags_register,
    input  wire logic [7:0]           io_byte,
    // program counter update
    output logic                      pc_load,
    output logic [15:0]               pc_value,
    output logic                      flags_we,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o
);
    import cbsu_pkg::*;

    cbsu_regs_t q;
    cbsu_regs_t next_q;
    logic       cond_taken;
    logic       cond_skip;
    logic       accept;
    logic [1:0] cost;
    logic [15:0] target;

    // ==========================================================
    // helpers
    function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [6:0] k);
        return pc + {{9{k[6]}}, k} + `CBSU_PC_STEP;
    endfunction

    function automatic logic [15:0] skip_target(input logic [15:0] pc, input logic two_word);
        return pc + (two_word ? `CBSU_SKIP_TWO_WORD : `CBSU_SKIP_ONE_WORD);
    endfunction

    // ==========================================================
    // condition evaluation
    cbsu_cond u_cond (
        .op        (insn.op),
        .bit_index (insn.bit_index),
        .flags     (status_flags_register),
        .io_byte   (io_byte),
        .taken     (cond_taken),
        .is_skip   (cond_skip)
    );

    // issue handshake and flag write enable
    assign insn_ready = (q.fsm == ST_IDLE) && q.enable;
    assign accept     = insn_valid && insn_ready;
    assign flags_we   = 1'b0;

    // ==========================================================
    // next pc and cycle cost
    always_comb
    begin
        if (!cond_taken)
        begin
            cost   = `CBSU_COST_ONE;
            target = insn.pc + `CBSU_PC_STEP;
        end
        else if (cond_skip)
        begin
            cost   = insn.next_two_word ? `CBSU_COST_THREE : `CBSU_COST_TWO;
            target = skip_target(insn.pc, insn.next_two_word);
        end
        else
        begin
            cost   = `CBSU_COST_TWO;
            target = rel_target(insn.pc, insn.offset);
        end
    end

    // ==========================================================
    // state update
    always_comb
    begin
        next_q      = q;
        next_q.done = 1'b0;
        case (q.fsm)
            ST_IDLE:
            begin
                if (accept)
                begin
                    next_q.insn     = insn;
                    next_q.flags    = status_flags_register;
                    next_q.io       = io_byte;
                    next_q.taken    = cond_taken;
                    next_q.pc_value = target;
                    if (cond_taken)
                        next_q.taken_count = q.taken_count + 16'h0001;
                    if (cost == `CBSU_COST_ONE)
                        next_q.done = 1'b1;
                    else
                    begin
                        next_q.fsm = ST_BUSY;
                        next_q.cnt = cost - `CBSU_COST_ONE;
                    end
                end
            end
            ST_BUSY:
            begin
                next_q.cnt = q.cnt - `CBSU_COST_ONE;
                if (q.cnt == `CBSU_COST_ONE)
                begin
                    next_q.done = 1'b1;
                    next_q.fsm  = ST_IDLE;
                end
            end
            default: next_q.fsm = ST_IDLE;
        endcase
        // wishbone: ack one cycle after request, writes land on the ack edge
        next_q.ack = wb_cyc_i && wb_stb_i && !q.ack;
        if (wb_cyc_i && wb_stb_i && !q.ack)
        begin
            case (wb_adr_i)
                `CBSU_ADDR_CTRL:   next_q.rdat = {31'h0, q.enable};
                `CBSU_ADDR_STATUS: next_q.rdat = {30'h0, q.taken, q.fsm == ST_BUSY};
                `CBSU_ADDR_COUNT:  next_q.rdat = {16'h0, q.taken_count};
                default:           next_q.rdat = 32'h0;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0] && wb_adr_i == `CBSU_ADDR_CTRL)
            next_q.enable = wb_dat_i[`CBSU_CTRL_EN_BIT];
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            q        <= '0;
            q.fsm    <= ST_IDLE;
            q.enable <= `CBSU_CTRL_RESET;
        end
        else
            q <= next_q;
    end

    // outputs
    assign pc_load  = q.done;
    assign pc_value = q.pc_value;
    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic [15:0] chk_seq;
    logic [15:0] chk_rel;
    logic [15:0] chk_skip;
    logic        chk_nv;
    assign chk_seq  = q.insn.pc + `CBSU_PC_STEP;
    // targets worked out independently of the helpers used by the datapath
    assign chk_rel  = q.insn.pc + {{9{q.insn.offset[6]}}, q.insn.offset} + `CBSU_PC_STEP;
    assign chk_skip = q.insn.pc + (q.insn.next_two_word ? `CBSU_SKIP_TWO_WORD : `CBSU_SKIP_ONE_WORD);
    assign chk_nv   = q.flags[`CBSU_FLAG_N] ^ q.flags[`CBSU_FLAG_V];

    skip_clear_a: assert property (
        pc_load && q.insn.op == OP_SKIP_IO_CLEAR |->
        pc_value == (q.io[q.insn.bit_index] ? chk_seq : chk_skip))
        else $error("skip on cleared io bit went to wrong pc");
    skip_set_a: assert property (
        pc_load && q.insn.op == OP_IO_BIT_SET_SKIP |->
        pc_value == (q.io[q.insn.bit_index] ? chk_skip : chk_seq))
        else $error("skip on set io bit went to wrong pc");
    flag_set_a: assert property (
        pc_load && q.insn.op == OP_BRANCH_FLAG_SET |->
        pc_value == (q.flags[q.insn.bit_index] ? chk_rel : chk_seq))
        else $error("branch on set flag went to wrong pc");
    flag_clear_a: assert property (
        pc_load && q.insn.op == OP_BRANCH_FLAG_CLEAR |->
        pc_value == (q.flags[q.insn.bit_index] ? chk_seq : chk_rel))
        else $error("branch on clear flag went to wrong pc");
    zero_branch_a: assert property (
        pc_load && (q.insn.op == OP_BRANCH_ON_EQUAL || q.insn.op == OP_BRANCH_ON_UNEQUAL) |->
        pc_value == ((q.flags[`CBSU_FLAG_Z] ^ (q.insn.op == OP_BRANCH_ON_UNEQUAL)) ? chk_rel : chk_seq))
        else $error("zero flag branch went to wrong pc");
    carry_branch_a: assert property (
        pc_load && (q.insn.op == OP_BRANCH_CARRY_SET || q.insn.op == OP_BRANCH_CARRY_CLEAR) |->
        pc_value == ((q.flags[`CBSU_FLAG_C] ^ (q.insn.op == OP_BRANCH_CARRY_CLEAR)) ? chk_rel : chk_seq))
        else $error("carry branch went to wrong pc");
    unsigned_cmp_a: assert property (
        pc_load && (q.insn.op == OP_BRANCH_UNSIGNED_GE || q.insn.op == OP_BRANCH_UNSIGNED_LT) |->
        pc_value == ((q.flags[`CBSU_FLAG_C] ^ (q.insn.op == OP_BRANCH_UNSIGNED_GE)) ? chk_rel : chk_seq))
        else $error("unsigned compare branch went to wrong pc");
    sign_branch_a: assert property (
        pc_load && (q.insn.op == OP_BRANCH_NEGATIVE || q.insn.op == OP_BRANCH_NONNEGATIVE) |->
        pc_value == ((q.flags[`CBSU_FLAG_N] ^ (q.insn.op == OP_BRANCH_NONNEGATIVE)) ? chk_rel : chk_seq))
        else $error("negative flag branch went to wrong pc");
    signed_ge_a: assert property (
        pc_load && q.insn.op == OP_BRANCH_SIGNED_GE |-> pc_value == (chk_nv ? chk_seq : chk_rel))
        else $error("signed ge branch went to wrong pc");
    signed_lt_a: assert property (
        pc_load && q.insn.op == OP_BRANCH_SIGNED_LT |-> pc_value == (chk_nv ? chk_rel : chk_seq))
        else $error("signed lt branch went to wrong pc");
    half_carry_a: assert property (
        pc_load && (q.insn.op == OP_BRANCH_HALFCARRY_SET || q.insn.op == OP_BRANCH_HALFCARRY_CLR) |->
        pc_value == ((q.flags[`CBSU_FLAG_H] ^ (q.insn.op == OP_BRANCH_HALFCARRY_CLR)) ? chk_rel : chk_seq))
        else $error("half carry branch went to wrong pc");
    transfer_bit_a: assert property (
        pc_load && q.insn.op == OP_BRANCH_TRANSFER_SET |->
        pc_value == (q.flags[`CBSU_FLAG_T] ? chk_rel : chk_seq))
        else $error("transfer bit branch went to wrong pc");
    flags_kept_a: assert property (
        accept |=> !flags_we && q.flags == $past(status_flags_register))
        else $error("status flags written or altered by branch or skip");
    short_cost_a: assert property (
        accept && !cond_taken |=> pc_load)
        else $error("untaken instruction not one cycle");
    branch_cost_a: assert property (
        accept && cond_taken && (cond_skip == 1'b0 || !insn.next_two_word) |=> !pc_load ##1 pc_load)
        else $error("taken branch or short skip not two cycles");
    long_skip_a: assert property (
        accept && cond_taken && cond_skip && insn.next_two_word |=> !pc_load [*2] ##1 pc_load)
        else $error("skip over two-word instruction not three cycles");

endmodule

// ===== cbsu_host_model.sv
// model of the fetch stage, status flags and io space around the unit
`timescale 1ns/1ps

module cbsu_host_model (
    // clock and unit outputs
    input  wire logic        core_clk,
    input  wire logic        pc_load,
    input  wire logic [15:0] pc_value,
    input  wire logic        flags_we,
    // state presented to the unit
    output logic [7:0]       status_flags_register,
    output logic [7:0]       io_byte
);
    // ==========================================================
    // held state
    logic [7:0]  flags_q  = 8'h00;
    logic [7:0]  io_q     = 8'h00;
    logic [15:0] fetch_pc = 16'h0000;

    // flags and io contents as the core shows them
    assign status_flags_register = flags_q;
    assign io_byte               = io_q;

    // new state, loaded by non-blocking assignment at a clock edge
    task automatic set_state(input logic [7:0] f, input logic [7:0] io);
        flags_q <= f;
        io_q <= io;
    endtask

    // fetch follows every pc load; a stray flag write clobbers the flags
    always @(posedge core_clk)
    begin
        if (pc_load === 1'b1)
            fetch_pc <= pc_value;
        if (flags_we === 1'b1)
            flags_q <= 8'h00;
    end
endmodule

// ===== conditional_branch_skip_unit_tb_top.sv
// self-checking testbench of the conditional branch and skip unit
`timescale 1ns/1ps

module conditional_branch_skip_unit_tb_top;
    import cbsu_pkg::*;

    // ==========================================================
    // signals
    logic        core_clk    = 1'b0;
    logic        rst_n       = 1'b0;
    logic        insn_valid  = 1'b0;
    cbsu_insn_t  insn        = '0;
    logic        wb_cyc_i    = 1'b0;
    logic        wb_stb_i    = 1'b0;
    logic        wb_we_i     = 1'b0;
    logic [7:0]  wb_adr_i    = 8'h00;
    logic [3:0]  wb_sel_i    = 4'h0;
    logic [31:0] wb_dat_i    = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        insn_ready;
    logic        pc_load;
    logic        flags_we;
    logic [15:0] pc_value;
    logic [7:0]  status_flags_register;
    logic [7:0]  io_byte;
    logic [31:0] rd;
    int          fails       = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    int          taken_n     = 0;

    // ==========================================================
    // unit and its surroundings
    cbsu_top DUT (.core_clk(core_clk), .rst_n(rst_n), .insn_valid(insn_valid), .insn(insn),
        .insn_ready(insn_ready), .status_flags_register(status_flags_register), .io_byte(io_byte),
        .pc_load(pc_load), .pc_value(pc_value), .flags_we(flags_we), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    cbsu_host_model HOST (.core_clk(core_clk), .pc_load(pc_load), .pc_value(pc_value),
        .flags_we(flags_we), .status_flags_register(status_flags_register), .io_byte(io_byte));

    // clock and hang guard
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            test_done();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic test_done();
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic bus cycle, held until ack
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                           output logic [31:0] rdat);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= wdat;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge core_clk);
    endtask

    // expected outcome of a condition
    function automatic logic cond(input int op, input logic [2:0] b, input logic [7:0] f, input logic [7:0] io);
        case (op)
            0: return !io[b];
            1: return io[b];
            2: return f[b];
            3: return !f[b];
            4: return f[1];
            5: return !f[1];
            6: return f[0];
            7: return !f[0];
            8: return !f[0];
            9: return f[0];
            10: return f[2];
            11: return !f[2];
            12: return !(f[2] ^ f[3]);
            13: return f[2] ^ f[3];
            14: return f[5];
            15: return !f[5];
            default: return f[6];
        endcase
    endfunction

    // issue one instruction and judge new pc, cost and flag writes
    task automatic issue(input int op, input logic [2:0] b, input logic [6:0] k, input logic two,
                         input logic [7:0] f, input logic [7:0] io, input logic [15:0] p);
        logic        c;
        logic [15:0] exp_pc;
        int          cost;
        int          n;
        c = cond(op, b, f, io);
        exp_pc = p + 16'h0001;
        cost = 1;
        if (c && op < 2)
        begin
            exp_pc = p + (two ? 16'h0003 : 16'h0002);
            cost = two ? 3 : 2;
        end
        else if (c)
        begin
            exp_pc = p + {{9{k[6]}}, k} + 16'h0001;
            cost = 2;
        end
        taken_n = taken_n + int'(c);
        @(posedge core_clk);
        insn_valid <= 1'b1;
        insn <= '{op: cbsu_op_t'(op), bit_index: b, offset: k, next_two_word: two, pc: p};
        HOST.set_state(f, io);
        do @(posedge core_clk); while (insn_ready !== 1'b1);
        insn_valid <= 1'b0;
        n = 1;
        #1;
        while (pc_load !== 1'b1 && n < 5)
        begin
            @(posedge core_clk);
            #1;
            n = n + 1;
        end
        check(32'(n), 32'(cost));
        check({16'h0, pc_value}, {16'h0, exp_pc});
        check({31'h0, flags_we}, 32'h0);
        check({24'h0, status_flags_register}, {24'h0, f});
        @(posedge core_clk);
        #1;
        check({16'h0, HOST.fetch_pc}, {16'h0, exp_pc});
    endtask

    // ==========================================================
    // scenarios
    task automatic branch_all();
        logic [7:0] fpat [4] = '{8'h00, 8'hff, 8'h04, 8'h08};
        logic [6:0] kpat [4] = '{7'h7e, 7'h3f, 7'h40, 7'h01};
        for (int op = 2; op <= 16; op++)
            for (int j = 0; j < 4; j++)
                issue(op, 3'(op + j), kpat[j], 1'b0, fpat[j], 8'h00, 16'h0040);
    endtask

    task automatic skip_all();
        for (int op = 0; op < 2; op++)
            for (int b = 0; b < 8; b++)
                for (int t = 0; t < 2; t++)
                    issue(op, 3'(b), 7'h00, t[0] ^ b[0], 8'hff, t[0] ? 8'h01 << b : ~(8'h01 << b), 16'hfffe);
    endtask

    // enable bit, unmapped place, refused issue, taken counter
    task automatic regs_check();
        wb_xfer(1'b0, 8'h04, 32'h0, rd);
        check(rd, 32'h2);
        wb_xfer(1'b0, 8'h00, 32'h0, rd);
        check(rd, 32'h1);
        wb_xfer(1'b0, 8'h40, 32'h0, rd);
        check(rd, 32'h0);
        wb_xfer(1'b1, 8'h00, 32'h0, rd);
        #1;
        check({31'h0, insn_ready}, 32'h0);
        @(posedge core_clk);
        insn_valid <= 1'b1;
        repeat (4)
        begin
            @(posedge core_clk);
            #1;
            check({31'h0, pc_load}, 32'h0);
        end
        @(posedge core_clk);
        insn_valid <= 1'b0;
        wb_xfer(1'b1, 8'h00, 32'h1, rd);
        wb_xfer(1'b0, 8'h08, 32'h0, rd);
        check(rd, {16'h0, 16'(taken_n)});
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        branch_all();
        skip_all();
        regs_check();
        test_done();
    end
endmodule
